// *** core/wake_bank_if.sv ***
// Signals between the register block and the edge detection bank
`timescale 1ns/1ps
`default_nettype none
interface wake_bank_if #(parameter int NUM_CH = 32);
  logic [NUM_CH-1:0] src;     // Raw wake sources
  logic [NUM_CH-1:0] mode;    // One selects falling edge
  logic [NUM_CH-1:0] enable;  // Channel enables
  logic [NUM_CH-1:0] clr;     // One-cycle clear of sense flags
  logic [NUM_CH-1:0] sense;   // Sense flags
  logic [NUM_CH-1:0] level;   // Synchronised source level
  logic [NUM_CH-1:0] evt;     // One-cycle enabled trigger

  // Register side
  modport ctrl (output src, mode, enable, clr, input sense, level, evt);
  // Detection side
  modport bank (input src, mode, enable, clr, output sense, level, evt);
endinterface
`default_nettype wire

// *** core/wake_edge_bank.sv ***
// Synchroniser, edge detector and sense flags for all wake channels
`timescale 1ns/1ps
`default_nettype none
module wake_edge_bank #(
  parameter int NUM_CH = 32
) (
  // Clock and reset
  input wire logic   mclk,
  input wire logic   rst_n,
  // Register block
  wake_bank_if.bank  bk
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_CH-1:0] s1;     // First synchroniser stage
    logic [NUM_CH-1:0] s2;     // Second synchroniser stage
    logic [NUM_CH-1:0] s3;     // Previous synchronised level
    logic [NUM_CH-1:0] sense;  // Sticky sense flags
  } bank_state_t;

  bank_state_t       st_r;     // Registered state
  bank_state_t       st_nxt;   // Next state
  logic [NUM_CH-1:0] hit;      // Selected edge seen

  // Next state: edge pick, enable gate, clear with set winning
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = bk.src;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    hit = (bk.mode & st_r.s3 & ~st_r.s2) | (~bk.mode & st_r.s2 & ~st_r.s3); // R8 R10
    st_nxt.sense = (st_r.sense & ~bk.clr) | (hit & bk.enable); // R3 R7
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bk.sense = st_r.sense;
  assign bk.level = st_r.s2;
  assign bk.evt   = hit & bk.enable; // R3

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_evt_sets;
    |bk.evt |=> ((st_r.sense & $past(bk.evt)) == $past(bk.evt));
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("Trigger did not set sense flag"); // R10

  property p_only_hw_sets;
    1'b1 |=> ((st_r.sense & ~$past(st_r.sense) & ~$past(bk.evt)) == '0);
  endproperty
  a_only_hw_sets: assert property (p_only_hw_sets) else $error("Sense flag set without trigger"); // R3

  property p_clear;
    |(bk.clr & ~bk.evt) |=> ((st_r.sense & $past(bk.clr & ~bk.evt)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("Write one did not clear sense flag"); // R7

  property p_edge_sel;
    bk.evt[0] |-> (bk.mode[0] ? ($past(bk.src[0], 3) && !$past(bk.src[0], 2))
                              : (!$past(bk.src[0], 3) && $past(bk.src[0], 2)));
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("Trigger on wrong edge"); // R8

endmodule
`default_nettype wire

// *** core/wake_event_pkg.sv ***
// Constants and helpers shared by the wake-up event controller
package wake_event_pkg;

  // ****************************************
  // Channel layout
  // ****************************************
  localparam int NUM_CH  = 32;           // Four groups of eight channels
  localparam int GRP_W   = 8;            // Channels per group
  localparam int NUM_GRP = 4;            // Group one .. group four

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [1:0] BANK_MODE   = 2'h0;  // Indices 0x0..0x3, edge mode per group
  localparam logic [1:0] BANK_SENSE  = 2'h1;  // Indices 0x4..0x7, sense flags per group
  localparam logic [1:0] BANK_ENABLE = 2'h2;  // Indices 0x8..0xb, enables per group
  localparam logic [1:0] BANK_IRQ    = 2'h3;  // Indices 0xc..0xf, interrupt registers
  localparam logic [3:0] IDX_ENABLE_G3 = 4'ha; // wake_enable_group_three
  localparam logic [3:0] IDX_ENABLE_G4 = 4'hb; // wake_enable_group_four
  localparam logic [3:0] IDX_IRQ_STAT  = 4'hc; // Sticky group event status
  localparam logic [3:0] IDX_IRQ_MASK  = 4'hd; // Interrupt mask

  // ****************************************
  // Reset values and channel positions
  // ****************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;  // Enables, modes and masks clear
  localparam int         CH_HOST    = 26;     // Host bus access channel
  localparam int         CH_SMB0    = 27;     // Bus wake event zero
  localparam int         GRP_THREE  = 2;      // Matrix scan inputs
  localparam int         GRP_FOUR   = 3;      // Mixed sources

  // Byte of one group out of a channel vector
  function automatic logic [7:0] grp_byte(input logic [NUM_CH-1:0] v, input int g);
    grp_byte = v[g*GRP_W +: GRP_W];
  endfunction

  // Any bit of one group set
  function automatic logic grp_any(input logic [NUM_CH-1:0] v, input int g);
    grp_any = |v[g*GRP_W +: GRP_W];
  endfunction

endpackage

// *** core/wake_event_unit.sv ***
// Wake-up event controller with Wishbone register access
// Functional notes
// R1: Enabled scan-input channels raise wake requests.
// R2: Enabled group-four channels raise wake requests.
// R3: Disabled channel discards triggers; enables reset clear.
// R4: Host access channel is rising-edge by default.
// R5: Bus wake events feed group four output.
// R6: Firmware keeps non-alternate pin channels disabled.
// R7: Sense flags set by hardware, write-one clears.
// R8: Mode zero rising edge, one falling edge.
// R9: Disabled group-two channels bypass to outputs.
// R10: Sources synchronised; selected edge sets sense flag.
`timescale 1ns/1ps
`default_nettype none
module wake_event_unit (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Wake sources
  input  wire logic [7:0]  ps2_clock_pin,
  input  wire logic [7:0]  general_wake_pin,
  input  wire logic        power_switch_input,
  input  wire logic        system_wake_module,
  input  wire logic [7:0]  matrix_scan_input,
  input  wire logic        host_access_hit,
  input  wire logic [1:0]  smbus_wake,
  // Power management and interrupt controller
  output logic             wake_request,
  output logic             group_one_irq_out,
  output logic             group_three_irq_out,
  output logic             group_four_irq_out,
  output logic [7:0]       per_channel_irq_out,
  output logic             irq
);

  localparam int N = wake_event_pkg::NUM_CH;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [N-1:0] mode;   // Edge mode bits
    logic [N-1:0] en;     // Enable bits
    logic [3:0]   stat;   // Sticky group event status
    logic [3:0]   mask;   // Interrupt mask
    logic         ack;    // Bus acknowledge
    logic [31:0]  rdat;   // Read data
  } unit_state_t;

  unit_state_t  st_r;     // Registered state
  unit_state_t  st_nxt;   // Next state
  logic [N-1:0] clr;      // Sense clear strobe
  logic [N-1:0] armed;    // Sense flags of enabled channels
  logic [3:0]   idx;      // Register index
  logic         req;      // Bus request open
  logic         wr;       // Write takes effect
  logic [7:0]   rbyte;    // Addressed register value

  wake_bank_if #(.NUM_CH(N)) bif ();

  // ****************************************
  // Source map and edge bank
  // ****************************************
  // Reserved channels are tied low so they never trigger
  assign bif.src = {1'b0, general_wake_pin[7:6], smbus_wake, host_access_hit, 1'b0, general_wake_pin[5],
                    matrix_scan_input,
                    1'b0, system_wake_module, power_switch_input, general_wake_pin[4:0],
                    ps2_clock_pin}; // R4 R5
  assign bif.mode   = st_r.mode;
  assign bif.enable = st_r.en;
  assign bif.clr    = clr;

  wake_edge_bank #(.NUM_CH(N)) u_bank (
    .mclk  (mclk),
    .rst_n (rst_n),
    .bk    (bif.bank)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign idx = wb_adr_i[5:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr  = req && wb_we_i && st_r.ack && wb_sel_i[0];

  // Read value of the addressed register; unmapped reads zero
  always_comb begin
    case (idx[3:2])
      wake_event_pkg::BANK_MODE:   rbyte = wake_event_pkg::grp_byte(st_r.mode, int'(idx[1:0]));
      wake_event_pkg::BANK_SENSE:  rbyte = wake_event_pkg::grp_byte(bif.sense, int'(idx[1:0]));
      wake_event_pkg::BANK_ENABLE: rbyte = wake_event_pkg::grp_byte(st_r.en, int'(idx[1:0]));
      default: begin
        if (idx == wake_event_pkg::IDX_IRQ_STAT) begin
          rbyte = {4'h0, st_r.stat};
        end else if (idx == wake_event_pkg::IDX_IRQ_MASK) begin
          rbyte = {4'h0, st_r.mask};
        end else begin
          rbyte = 8'h00;
        end
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt     = st_r;
    clr        = '0;
    st_nxt.ack = req && !st_r.ack;
    // Read data captured as the acknowledge rises
    if (req && !st_r.ack) begin
      st_nxt.rdat = {24'h000000, rbyte};
    end
    // Writes land at the edge where the master sees ack
    if (wr) begin
      case (idx[3:2])
        wake_event_pkg::BANK_MODE:   st_nxt.mode[idx[1:0]*8 +: 8] = wb_dat_i[7:0]; // R8
        wake_event_pkg::BANK_SENSE:  clr[idx[1:0]*8 +: 8] = wb_dat_i[7:0]; // R7
        wake_event_pkg::BANK_ENABLE: st_nxt.en[idx[1:0]*8 +: 8] = wb_dat_i[7:0]; // R1 R2
        default: begin
          if (idx == wake_event_pkg::IDX_IRQ_STAT) begin
            st_nxt.stat = st_r.stat & ~wb_dat_i[3:0];
          end else if (idx == wake_event_pkg::IDX_IRQ_MASK) begin
            st_nxt.mask = wb_dat_i[3:0];
          end
        end
      endcase
    end
    // Group events set status after any clear, so the set wins
    for (int g = 0; g < wake_event_pkg::NUM_GRP; g++) begin
      if (wake_event_pkg::grp_any(bif.evt, g)) begin
        st_nxt.stat[g] = 1'b1;
      end
    end
  end

  // State register; enables and modes clear at reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0; // R3 R4
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign armed    = bif.sense & st_r.en;
  // Pending enabled flags request wake-up
  assign wake_request        = |armed; // R1 R2
  assign group_one_irq_out   = wake_event_pkg::grp_any(armed, 0);
  assign group_three_irq_out = wake_event_pkg::grp_any(armed, wake_event_pkg::GRP_THREE);
  assign group_four_irq_out  = wake_event_pkg::grp_any(armed, wake_event_pkg::GRP_FOUR); // R5
  // Group two: enabled channels processed, disabled ones pass the level
  assign per_channel_irq_out = (wake_event_pkg::grp_byte(armed, 1)) |
                               (~wake_event_pkg::grp_byte(st_r.en, 1) & wake_event_pkg::grp_byte(bif.level, 1)); // R9
  assign irq = |(st_r.stat & st_r.mask);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_g3_request;
    (bif.evt[wake_event_pkg::GRP_THREE*8] && st_r.en[wake_event_pkg::GRP_THREE*8]) |=> wake_request [*2];
  endproperty
  a_g3_request: assert property (p_g3_request) else $error("Scan channel trigger gave no request"); // R1

  property p_g4_out;
    (bif.evt[wake_event_pkg::CH_SMB0] && st_r.en[wake_event_pkg::CH_SMB0]) |=> group_four_irq_out;
  endproperty
  a_g4_out: assert property (p_g4_out) else $error("Bus wake event missing on group four output"); // R2 R5

  // With every channel off, no request and no new sense flag next cycle
  property p_disabled_quiet;
    (st_r.en == '0) |-> !wake_request ##1 ((bif.sense & ~$past(bif.sense)) == '0);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled channels requested wake"); // R3

  property p_host_rise;
    (!st_r.mode[wake_event_pkg::CH_HOST] && st_r.en[wake_event_pkg::CH_HOST] && !host_access_hit ##1
     host_access_hit && $stable(st_r.mode) && $stable(st_r.en)) |-> ##2 bif.evt[wake_event_pkg::CH_HOST];
  endproperty
  a_host_rise: assert property (p_host_rise) else $error("Host access rise not detected"); // R4

  property p_bypass;
    !st_r.en[8] |-> (per_channel_irq_out[0] == bif.level[8]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Disabled channel not bypassed"); // R9

  property p_ack_pulse;
    (req && !st_r.ack) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge not a single cycle");

  // Group one trigger sets its status bit, even against a clear
  property p_stat_set;
    (|bif.evt[7:0]) |=> st_r.stat[0];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("Group one trigger left status clear"); // R10

  // Scan group enable write lands at the acknowledge edge
  property p_en_g3_write;
    (wr && idx == wake_event_pkg::IDX_ENABLE_G3) |=>
      (st_r.en[wake_event_pkg::GRP_THREE*8 +: 8] == $past(wb_dat_i[7:0]));
  endproperty
  a_en_g3_write: assert property (p_en_g3_write) else $error("Scan group enable write lost"); // R1

  // Group four enable write lands at the acknowledge edge
  property p_en_g4_write;
    (wr && idx == wake_event_pkg::IDX_ENABLE_G4) |=>
      (st_r.en[wake_event_pkg::GRP_FOUR*8 +: 8] == $past(wb_dat_i[7:0]));
  endproperty
  a_en_g4_write: assert property (p_en_g4_write) else $error("Group four enable write lost"); // R2

  c_wake:   cover property (wake_request);
  c_bypass: cover property (!st_r.en[8] && per_channel_irq_out[0]);
  c_irq:    cover property (irq ##1 !irq);
  c_host:   cover property (bif.evt[wake_event_pkg::CH_HOST]);

endmodule
`default_nettype wire

// *** tb/wake_event_unit_tb.sv ***
// Self-checking bench for the wake-up event controller
`timescale 1ns/1ps
`default_nettype none
module wake_event_unit_tb;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam logic [31:0] VALID = 32'h7dff_7fff;  // Reserved channels stay low
  logic        mclk = 1'b0;      // 100 MHz clock
  logic        rst_n = 1'b0;     // Reset, active low
  logic        cyc = 1'b0;       // Bus cycle
  logic        we = 1'b0;        // Bus direction
  logic [5:0]  adr = 6'h00;      // Byte address
  logic [31:0] dat = 32'h0;      // Write data
  logic [3:0]  sel = 4'hf;       // Byte lanes
  logic [31:0] dat_o;            // Read data
  logic        ack;              // Bus answer
  logic [31:0] src_r = 32'h0;    // Source levels by channel
  logic        wake, g1, g3, g4, irq, seen;  // Outputs under test
  logic [7:0]  pch;              // Per-channel outputs
  logic [31:0] en_m, mode_m, sense_m, prev, nxt, hit;  // Reference model
  logic [3:0]  stat_m, mask_m;   // Model status and mask
  logic [31:0] rd;               // Read scratch
  int          n_fail = 0;       // Mismatches
  int          comparisons = 0;  // Checks made
  int          cycles = 0;       // Timeout counter

  always #5 mclk = ~mclk;

  // ****************************************
  // Design and far side
  // ****************************************
  wake_event_unit u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ps2_clock_pin(src_r[7:0]), .general_wake_pin({src_r[30:29], src_r[24], src_r[12:8]}),
    .power_switch_input(src_r[13]), .system_wake_module(src_r[14]), .matrix_scan_input(src_r[23:16]),
    .host_access_hit(src_r[26]), .smbus_wake(src_r[28:27]), .wake_request(wake),
    .group_one_irq_out(g1), .group_three_irq_out(g3), .group_four_irq_out(g4),
    .per_channel_irq_out(pch), .irq(irq));
  wake_pm_model u_pm (.mclk(mclk), .rst_n(rst_n), .wake_request(wake), .wake_seen(seen));

  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    we  <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, wd};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = dat_o;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  // Registers and outputs against the model
  task automatic check_all;
    for (int g = 0; g < 4; g++) begin
      wb(1'b0, 4'(g), 8'h00);
      chk(rd, {24'h0, mode_m[g*8 +: 8]});
      wb(1'b0, 4'(4 + g), 8'h00);
      chk(rd, {24'h0, sense_m[g*8 +: 8]});
      wb(1'b0, 4'(8 + g), 8'h00);
      chk(rd, {24'h0, en_m[g*8 +: 8]});
    end
    wb(1'b0, wake_event_pkg::IDX_IRQ_STAT, 8'h00);
    chk(rd, {28'h0, stat_m});
    wb(1'b0, wake_event_pkg::IDX_IRQ_MASK, 8'h00);
    chk(rd, {28'h0, mask_m});
    @(negedge mclk);
    chk(32'(wake), 32'(|(sense_m & en_m)));
    chk(32'(g1), 32'(|(sense_m[7:0] & en_m[7:0])));
    chk(32'(g3), 32'(|(sense_m[23:16] & en_m[23:16])));
    chk(32'(g4), 32'(|(sense_m[31:24] & en_m[31:24])));
    chk(32'(pch), 32'((en_m[15:8] & sense_m[15:8]) | (~en_m[15:8] & src_r[15:8])));
    chk(32'(irq), 32'(|(stat_m & mask_m)));
  endtask

  // Closing verdict
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hcb09));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // Every index reads zero after reset, unmapped ones too
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, 4'(i), 8'h00);
      chk(rd, 32'h0);
    end
    // A write without the low byte lane is ignored
    sel <= 4'he;
    wb(1'b1, wake_event_pkg::IDX_ENABLE_G4, 8'hff);
    sel <= 4'hf;
    wb(1'b0, wake_event_pkg::IDX_ENABLE_G4, 8'h00);
    chk(rd, 32'h0);
    for (int it = 0; it < 24; it++) begin
      // Stimulus treats every pin as in its alternate function
      en_m   = (it == 0) ? VALID : $urandom & VALID;
      mode_m = (it == 0) ? 32'h0 : $urandom;
      mask_m = 4'($urandom);
      for (int g = 0; g < 4; g++) begin
        wb(1'b1, 4'(g), mode_m[g*8 +: 8]);
        wb(1'b1, 4'(8 + g), en_m[g*8 +: 8]);
      end
      wb(1'b1, wake_event_pkg::IDX_IRQ_MASK, 8'(mask_m));
      // Mode change may leave a stray flag, so wipe afterwards
      repeat (4) @(posedge mclk);
      for (int g = 0; g < 4; g++) wb(1'b1, 4'(4 + g), 8'hff);
      wb(1'b1, wake_event_pkg::IDX_IRQ_STAT, 8'h0f);
      prev = src_r;
      nxt  = (it == 0) ? (~prev & VALID) : ($urandom & VALID);
      @(posedge mclk);
      src_r <= nxt;
      repeat (6) @(posedge mclk);
      // Selected edge on enabled channels only
      hit = en_m & (mode_m & prev & ~nxt | ~mode_m & ~prev & nxt);
      sense_m = hit;
      for (int g = 0; g < 4; g++) stat_m[g] = |hit[g*8 +: 8];
      check_all();
      // Partial write-one clear, zeros leave flags alone
      for (int g = 0; g < 4; g++) begin
        hit[g*8 +: 8] = 8'($urandom);
        wb(1'b1, 4'(4 + g), hit[g*8 +: 8]);
      end
      sense_m = sense_m & ~hit;
      wb(1'b1, wake_event_pkg::IDX_IRQ_STAT, {4'h0, hit[3:0]});
      stat_m = stat_m & ~hit[3:0];
      check_all();
    end
    chk(32'(seen), 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** tb/wake_pm_model.sv ***
// Power management side that watches the wake request line
`timescale 1ns/1ps
`default_nettype none
module wake_pm_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Wake request from the controller
  input  wire logic wake_request,
  // Sticky note that a wake was ever seen
  output logic      wake_seen
);
  // ****************************************
  // Latch any wake request, as the power logic would leave sleep
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen <= 1'b0;
    end else if (wake_request) begin
      wake_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire
